/* dv/ivs_cpu_model.sv */
// CPU core stand-in: retires instructions, checks stacking order, logs vectors.
// Assumes it shares the system clock and synchronous reset with the block.
`timescale 1ns/10ps
module ivs_cpu_model (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_busy, // Sequencer active
	input wire logic i_push, // Push strobe
	input wire logic i_pop, // Pop strobe
	input wire logic [1:0] i_sel, // Stacked register
	input wire logic i_pc_load, // Vector load
	input wire logic [15:0] i_vector, // Vector address
	input wire logic i_sleep, // WAIT or HALT
	output logic o_instr_end = 1'b0 // Instruction boundary
);
	logic [15:0] vq[$];
	int seq_err = 0;
	logic [1:0] push_sel_reg;
	logic [1:0] pop_sel_reg;
	// ********************************
	// Core behaviour
	// ********************************
	// One instruction a cycle; stalls while stacking, so the block sees no boundary then
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_instr_end <= 1'b0;
			push_sel_reg <= 2'h0;
			pop_sel_reg <= 2'h3;
		end else begin
			o_instr_end <= !i_busy && !i_sleep;
			if (i_push) begin
				if (i_sel !== push_sel_reg) seq_err <= seq_err + 1;
				push_sel_reg <= push_sel_reg + 2'h1;
			end
			if (i_pop) begin
				if (i_sel !== pop_sel_reg) seq_err <= seq_err + 1;
				pop_sel_reg <= pop_sel_reg - 2'h1;
			end
			if (i_pc_load) vq.push_back(i_vector);
		end
	end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the interrupt block with supply-integrity register.
// Assumes the core stand-in model drives the instruction boundary.
`timescale 1ns/10ps
module tb_top;
	import ivs_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_uv_cause = 1'b1;
	logic [ADDR_W-1:0] i_addr = 8'h00;
	logic [DATA_W-1:0] i_wdata = 8'h00;
	logic i_wr = 1'b0, i_rd = 1'b0, i_sw_cmp = 1'b0, i_pll_lock = 1'b1, i_instr_end;
	logic i_trap = 1'b0, i_ret_int = 1'b0, i_wfi = 1'b0, i_halt = 1'b0, i_mask = 1'b0, i_unmask = 1'b0;
	logic [NPIN-1:0] i_ext_pin = 8'hFF, i_ext_pin_ie = 8'h01;
	logic [2*NEXT-1:0] i_ext_sens = 8'h55;
	logic [NPER-1:0] i_per_set = 5'h00, i_per_clr = 5'h00, i_per_en = 5'h1F;
	logic [DATA_W-1:0] o_rdata;
	logic o_imask, o_busy, o_push, o_pop, o_pc_load, o_wait, o_halt;
	logic [1:0] o_stk_sel;
	logic [15:0] o_vector;
	int fail_count = 0, checked = 0, seed = 32'h4ae9, idx;
	logic [7:0] rv;
	logic uv_m, en_m;

	// Free-running 100 MHz clock
	always #5 i_sys_clk = ~i_sys_clk;

	ivs_intc dut_u (.i_sys_clk, .i_rst_n, .i_uv_cause, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sw_cmp,
		.i_pll_lock, .i_ext_pin, .i_ext_pin_ie, .i_ext_sens, .i_per_set, .i_per_clr, .i_per_en, .i_instr_end,
		.i_trap, .i_ret_int, .i_wfi, .i_halt, .i_mask, .i_unmask, .o_imask, .o_busy, .o_push, .o_pop,
		.o_stk_sel, .o_pc_load, .o_vector, .o_wait, .o_halt);
	ivs_cpu_model cpu_u (.i_sys_clk, .i_rst_n, .i_busy(o_busy), .i_push(o_push), .i_pop(o_pop),
		.i_sel(o_stk_sel), .i_pc_load(o_pc_load), .i_vector(o_vector), .i_sleep(o_wait | o_halt),
		.o_instr_end(i_instr_end));

	// ********************************
	// Shared tasks
	// ********************************
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// Model of the status byte: reserved bits read zero, flag follows the comparator
	function automatic logic [7:0] exp_stat();
		return {RSVD_READ, i_pll_lock, uv_m, i_sw_cmp, en_m};
	endfunction
	task automatic rst(input logic uv);
		@(posedge i_sys_clk);
		i_rst_n <= 1'b0;
		i_uv_cause <= uv;
		tick(12);
		i_rst_n <= 1'b1;
		i_uv_cause <= 1'b0;
		if (uv) uv_m = 1'b1;
		en_m = 1'b0;
		// Lock and pin levels need the synchroniser depth before they read true
		tick(8);
		cpu_u.vq.delete();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		if (a == SI_STATUS_OFF) begin
			en_m = d[BIT_SW_IRQ_EN];
			if (!d[BIT_UV_RST]) uv_m = 1'b0;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		chk("status", {8'h00, o_rdata}, {8'h00, exp});
		@(posedge i_sys_clk);
	endtask
	// Codes: 0 mask, 1 unmask, 2 trap, 3 wait, 4 halt, 5 return
	task automatic cmd(input int c);
		@(posedge i_sys_clk);
		case (c)
			0: i_mask <= 1'b1;
			1: i_unmask <= 1'b1;
			2: i_trap <= 1'b1;
			3: i_wfi <= 1'b1;
			4: i_halt <= 1'b1;
			default: i_ret_int <= 1'b1;
		endcase
		@(posedge i_sys_clk);
		{i_mask, i_unmask, i_trap, i_wfi, i_halt, i_ret_int} <= 6'h00;
	endtask
	task automatic pset(input logic [NPER-1:0] s, input logic [NPER-1:0] c);
		@(posedge i_sys_clk);
		i_per_set <= s;
		i_per_clr <= c;
		@(posedge i_sys_clk);
		i_per_set <= 5'h00;
		i_per_clr <= 5'h00;
	endtask
	task automatic idle();
		int t;
		t = 0;
		@(negedge i_sys_clk);
		while (o_busy && t < 40) begin
			@(negedge i_sys_clk);
			t++;
		end
	endtask
	// Expect one service of source n (-1 is the trap), clear peripheral flags inside, then return
	task automatic serv(input int n, input logic [NPER-1:0] clr);
		int t;
		t = 0;
		while (cpu_u.vq.size() == 0 && t < 80) begin
			@(negedge i_sys_clk);
			t++;
		end
		chk("vector", cpu_u.vq.size() > 0 ? cpu_u.vq.pop_front() : 16'h0000, 16'hFFFA - 16'(2 * n));
		if (clr != 5'h00) pset(5'h00, clr);
		idle();
		chk("mask in routine", o_imask, 1'b1);
		cmd(5);
		idle();
		chk("mask after return", o_imask, 1'b0);
		// Hand back on a rising edge so later stimulus lands on the clock
		@(posedge i_sys_clk);
	endtask
	task automatic none(input int n);
		tick(n);
		chk("no service", 16'(cpu_u.vq.size()), 16'h0000);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rst(1'b1);
		chk("reset vector", o_vector, VEC_RESET);
		chk("mask at reset", o_imask, 1'b1);
		rd_chk(SI_STATUS_OFF, exp_stat());
		rst(1'b0);
		rd_chk(SI_STATUS_OFF, exp_stat());
		wr(SI_STATUS_OFF, 8'h01);
		rd_chk(SI_STATUS_OFF, exp_stat());
		i_pll_lock <= 1'b0;
		tick(6);
		rd_chk(SI_STATUS_OFF, exp_stat());
		i_pll_lock <= 1'b1;
		wr(SI_STATUS_OFF, 8'h00);
		rv = 8'($random(seed));
		rd_chk(rv | 8'h40, UNMAPPED_READ);
		// Warning change with the enable off raises nothing, even unmasked
		cmd(1);
		i_sw_cmp <= 1'b1;
		none(20);
		rd_chk(SI_STATUS_OFF, exp_stat());
		i_sw_cmp <= 1'b0;
		tick(10);
		wr(SI_STATUS_OFF, 8'h01);
		// Both directions of the flag each give exactly one request
		repeat (2) begin
			i_sw_cmp <= ~i_sw_cmp;
			serv(SRC_SW, 5'h00);
			none(12);
		end
		// Requests held while masked, then taken by priority
		cmd(0);
		@(posedge i_sys_clk);
		i_ext_pin[0] <= 1'b0;
		pset(5'h11, 5'h00);
		none(12);
		cmd(1);
		serv(SRC_EXT0, 5'h00);
		serv(SRC_PER0, 5'h01);
		serv(SRC_PER0 + 4, 5'h10);
		i_ext_pin[0] <= 1'b1;
		none(12);
		// Disabled peripheral stays pending, then the clear sequence drops it
		i_per_en <= 5'h1B;
		pset(5'h04, 5'h00);
		none(10);
		pset(5'h00, 5'h04);
		i_per_en <= 5'h1F;
		none(10);
		idx = $unsigned($random(seed)) % NPER;
		pset(5'(1 << idx), 5'h00);
		serv(SRC_PER0 + idx, 5'(1 << idx));
		cmd(0);
		cmd(2);
		serv(-1, 5'h00);
		// Two enabled pins on one line: a low pin holds the combined level
		i_ext_pin_ie <= 8'h03;
		tick(2);
		i_ext_pin[1] <= 1'b0;
		serv(SRC_EXT0, 5'h00);
		i_ext_pin[0] <= 1'b0;
		none(12);
		i_ext_pin <= 8'hFF;
		i_ext_pin_ie <= 8'h01;
		tick(10);
		// Line 0 in both-edge, falling-only and falling-plus-level modes
		i_ext_sens <= 8'h57;
		i_ext_pin[0] <= 1'b0;
		serv(SRC_EXT0, 5'h00);
		i_ext_pin[0] <= 1'b1;
		serv(SRC_EXT0, 5'h00);
		i_ext_sens <= 8'h56;
		i_ext_pin[0] <= 1'b0;
		none(12);
		i_ext_pin[0] <= 1'b1;
		serv(SRC_EXT0, 5'h00);
		i_ext_pin[0] <= 1'b0;
		tick(8);
		i_ext_sens <= 8'h54;
		none(12);
		// A low level keeps requesting after the latch is acknowledged
		i_ext_pin[0] <= 1'b1;
		serv(SRC_EXT0, 5'h00);
		i_ext_pin[0] <= 1'b0;
		serv(SRC_EXT0, 5'h00);
		none(12);
		i_ext_sens <= 8'h55;
		i_ext_pin[0] <= 1'b1;
		tick(10);
		// WAIT is left on a warning change
		cmd(3);
		@(negedge i_sys_clk);
		chk("in wait", o_wait, 1'b1);
		@(posedge i_sys_clk);
		i_sw_cmp <= 1'b1;
		serv(SRC_SW, 5'h00);
		chk("wait left", o_wait, 1'b0);
		// HALT ignores warning changes but an external line wakes it
		cmd(4);
		i_sw_cmp <= 1'b0;
		tick(10);
		i_sw_cmp <= 1'b1;
		tick(10);
		chk("still halted", o_halt, 1'b1);
		i_ext_pin[0] <= 1'b0;
		serv(SRC_EXT0, 5'h00);
		chk("halt left", o_halt, 1'b0);
		i_ext_pin[0] <= 1'b1;
		tick(10);
		chk("stack order", 16'(cpu_u.seq_err), 16'h0000);
		results();
	end

	// Watchdog: the whole run needs well under this many cycles
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		results();
	end
endmodule

/* hdl/ivs_ext_line.sv */
// One external interrupt line: edge/level detection and request latch.
// Assumes the combined pin level is already synchronised.
`timescale 1ns/10ps
module ivs_ext_line
	import ivs_pkg::*;
(
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Synchronous reset, active low
	ivs_line_if.line bus // Level, sensitivity, ack and request
);
	typedef struct packed {
		logic prev;
		logic pend;
	} ivs_line_st_t;

	ivs_line_st_t st_reg;
	ivs_line_st_t st_next;
	logic rise;
	logic fall;
	logic hit;

	// Edge classification against the chosen sensitivity
	always_comb begin
		rise = bus.lvl && !st_reg.prev;
		fall = !bus.lvl && st_reg.prev;
		unique case (bus.sens)
			SENS_RISE: hit = rise;
			SENS_BOTH: hit = rise || fall;
			SENS_FALL, SENS_FALL_LOW: hit = fall;
		endcase
	end

	// latch and auto-clear
	// A new edge in the ack cycle is kept, so no event is lost
	always_comb begin
		st_next = st_reg;
		st_next.prev = bus.lvl;
		if (bus.ack) begin
			st_next.pend = 1'b0;
		end
		if (hit) begin
			st_next.pend = 1'b1;
		end
		if (!i_rst_n) begin
			st_next.prev = RST_LINE_PREV;
			st_next.pend = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st_reg <= st_next;
	end

	// Low-level mode also requests while the line stays low
	assign bus.req = st_reg.pend || (bus.sens == SENS_FALL_LOW && !bus.lvl);

	edge_ack_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		bus.ack && !hit |=> !st_reg.pend)
		else $error("line request not cleared on service entry");
endmodule

/* hdl/ivs_intc.sv */
// Interrupt controller with supply-integrity status register.
// Assumes the CPU core pushes and pops on the strobes given here and stalls while o_busy.
`timescale 1ns/10ps
module ivs_intc
	import ivs_pkg::*;
(
	input wire logic i_sys_clk, // 100 MHz CPU clock
	input wire logic i_rst_n, // Synchronous system reset, active low
	input wire logic i_uv_cause, // Reset comes from the under-voltage detector
	input wire logic [ivs_pkg::ADDR_W-1:0] i_addr, // Register address
	input wire logic [ivs_pkg::DATA_W-1:0] i_wdata, // Register write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [ivs_pkg::DATA_W-1:0] o_rdata, // Read data, cycle after strobe
	input wire logic i_sw_cmp, // Supply-warning comparator, 1 below threshold
	input wire logic i_pll_lock, // PLL at operating frequency
	input wire logic [ivs_pkg::NPIN-1:0] i_ext_pin, // External interrupt pins
	input wire logic [ivs_pkg::NPIN-1:0] i_ext_pin_ie, // Pin interrupt enables
	input wire logic [2*ivs_pkg::NEXT-1:0] i_ext_sens, // Two sensitivity bits per line
	input wire logic [ivs_pkg::NPER-1:0] i_per_set, // Peripheral flag set pulses
	input wire logic [ivs_pkg::NPER-1:0] i_per_clr, // Peripheral clear sequence pulses
	input wire logic [ivs_pkg::NPER-1:0] i_per_en, // Peripheral interrupt enables
	input wire logic i_instr_end, // Current instruction finishes
	input wire logic i_trap, // Trap instruction, with i_instr_end
	input wire logic i_ret_int, // Return from interrupt executes
	input wire logic i_wfi, // Wait instruction, with i_instr_end
	input wire logic i_halt, // Halt instruction, with i_instr_end
	input wire logic i_mask, // Set global mask
	input wire logic i_unmask, // Clear global mask
	output logic o_imask, // Global interrupt mask
	output logic o_busy, // Sequencer active, core stalls
	output logic o_push, // Push one register
	output logic o_pop, // Pop one register
	output logic [1:0] o_stk_sel, // 0 PC, 1 X, 2 A, 3 CC
	output logic o_pc_load, // Load PC from o_vector
	output logic [15:0] o_vector, // Vector address
	output logic o_wait, // In WAIT
	output logic o_halt // In HALT
);
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic sw_irq_en;
		logic uv_flag;
		logic sw_flag;
		logic lock;
		logic sw_pend;
		logic [NPER-1:0] per_pend;
		logic imask;
		ivs_mode_t mode;
		ivs_seq_t seq;
		logic [1:0] step;
		logic [3:0] idx;
		logic [15:0] vector;
	} ivs_st_t;

	ivs_st_t cur;
	ivs_st_t nxt;

	// ********************************
	// Input capture
	// ********************************
	logic [NPIN+1:0] sync_q;
	logic [NPIN-1:0] pin_s;
	logic sw_s;
	logic lock_s;

	// Pins and analog levels come from outside the clock domain
	ivs_sync #(.W(NPIN + 2)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_pll_lock, i_sw_cmp, i_ext_pin}),
		.o_q(sync_q)
	);

	assign pin_s = sync_q[NPIN-1:0];
	assign sw_s = sync_q[NPIN];
	assign lock_s = sync_q[NPIN+1];

	// ********************************
	// External lines
	// ********************************
	ivs_line_if u_line_if[NEXT] ();
	logic [NEXT-1:0] ext_req;
	logic [NEXT-1:0] ext_ack;

	for (genvar g = 0; g < NEXT; g++) begin : g_line
		logic [PINS_PER_LINE-1:0] pins;
		logic [PINS_PER_LINE-1:0] ies;
		assign pins = pin_s[g*PINS_PER_LINE +: PINS_PER_LINE];
		assign ies = i_ext_pin_ie[g*PINS_PER_LINE +: PINS_PER_LINE];
		// shared pin NAND
		// Disabled pins count as high; a line with no enabled pin rests high
		assign u_line_if[g].lvl = (|ies) ? ~&(pins | ~ies) : 1'b1;
		assign u_line_if[g].sens = i_ext_sens[2*g +: 2];
		assign u_line_if[g].ack = ext_ack[g];
		assign ext_req[g] = u_line_if[g].req;
		ivs_ext_line u_line (
			.i_sys_clk(i_sys_clk),
			.i_rst_n(i_rst_n),
			.bus(u_line_if[g])
		);
	end

	// ********************************
	// Request gathering and priority
	// ********************************
	logic [NSRC-1:0] req_vec;
	logic [NSRC-1:0] svc;
	logic [3:0] win;
	logic trap_take;
	logic sw_change;
	logic [DATA_W-1:0] status_val;

	// enable and mask gating
	// Peripheral requests stay latched until the clear sequence; enable and mask only gate them here
	always_comb begin
		req_vec = '0;
		req_vec[SRC_EXT0 +: NEXT] = ext_req;
		req_vec[SRC_SW] = cur.sw_pend;
		req_vec[SRC_PER0 +: NPER] = cur.per_pend & i_per_en;
		svc = cur.imask ? '0 : req_vec;
		if (cur.mode == MD_HALT) begin
			svc = svc & HALT_WAKE;
		end
		win = SRC_NONE;
		for (int i = NSRC - 1; i > 0; i--) begin
			if (svc[i]) begin
				win = 4'(i);
			end
		end
	end

	assign trap_take = cur.seq == SQ_IDLE && cur.mode == MD_RUN && i_instr_end && i_trap;
	assign sw_change = sw_s != cur.sw_flag;
	assign status_val = {RSVD_READ, cur.lock, cur.uv_flag, cur.sw_flag, cur.sw_irq_en};

	// ********************************
	// Next-state logic
	// ********************************
	always_comb begin
		nxt = cur;
		ext_ack = '0;

		// peripheral clear
		// A set in the clear cycle survives
		nxt.per_pend = (cur.per_pend & ~i_per_clr) | i_per_set;

		// Register port; the register is frozen while halted
		if (i_rd) begin
			nxt.rdata = (i_addr == SI_STATUS_OFF) ? status_val : UNMAPPED_READ;
		end
		if (i_wr && i_addr == SI_STATUS_OFF && cur.mode != MD_HALT) begin
			nxt.sw_irq_en = i_wdata[BIT_SW_IRQ_EN];
			if (!i_wdata[BIT_UV_RST]) begin
				nxt.uv_flag = 1'b0;
			end
		end

		unique case (cur.seq)
			SQ_RSTV: begin
				nxt.seq = SQ_IDLE;
			end
			SQ_IDLE: begin
				if (i_mask) begin
					nxt.imask = 1'b1;
				end
				if (i_unmask) begin
					nxt.imask = 1'b0;
				end
				if (trap_take) begin
					nxt.seq = SQ_PUSH;
					nxt.step = '0;
					nxt.idx = SRC_NONE;
					nxt.vector = VEC_TRAP;
				end else if ((cur.mode != MD_RUN || i_instr_end) && win != SRC_NONE) begin
					nxt.mode = MD_RUN;
					nxt.seq = SQ_PUSH;
					nxt.step = '0;
					nxt.idx = win;
					nxt.vector = VEC_BASE - {11'h000, win, 1'b0};
				end else if (cur.mode == MD_RUN && i_ret_int) begin
					nxt.seq = SQ_POP;
					nxt.step = '0;
				end else if (cur.mode == MD_RUN && i_instr_end && (i_wfi || i_halt)) begin
					// Low-power entry unmasks so a pending request wakes WAIT at once, and HALT if it is in HALT_WAKE
					nxt.mode = i_halt ? MD_HALT : MD_WAIT;
					nxt.imask = 1'b0;
				end
			end
			SQ_PUSH: begin
				nxt.step = cur.step + 2'h1;
				if (cur.step == STK_LAST) begin
					nxt.seq = SQ_LOAD;
				end
			end
			SQ_LOAD: begin
				nxt.imask = 1'b1;
				nxt.seq = SQ_IDLE;
				for (int l = 0; l < NEXT; l++) begin
					if (cur.idx == 4'(SRC_EXT0 + l)) begin
						ext_ack[l] = 1'b1;
					end
				end
				if (cur.idx == SRC_SW) begin
					nxt.sw_pend = 1'b0;
				end
			end
			SQ_POP: begin
				nxt.step = cur.step + 2'h1;
				if (cur.step == STK_LAST) begin
					nxt.imask = 1'b0;
					nxt.seq = SQ_IDLE;
				end
			end
			default: begin
				nxt.seq = SQ_IDLE;
			end
		endcase

		if (cur.mode != MD_HALT) begin
			nxt.lock = lock_s;
			nxt.sw_flag = sw_s;
			if (sw_change && cur.sw_irq_en) begin
				nxt.sw_pend = 1'b1;
			end
		end

		// flag survives other resets
		// The flag is deliberately outside the reset so earlier causes remain visible
		if (!i_rst_n) begin
			nxt = '0;
			nxt.uv_flag = i_uv_cause ? 1'b1 : cur.uv_flag;
			nxt.imask = RST_IMASK;
			nxt.mode = MD_RUN;
			nxt.seq = SQ_RSTV;
			nxt.vector = VEC_RESET;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		cur <= nxt;
	end

	// ********************************
	// Outputs
	// ********************************
	assign o_rdata = cur.rdata;
	assign o_imask = cur.imask;
	assign o_busy = cur.seq != SQ_IDLE;
	assign o_push = cur.seq == SQ_PUSH;
	assign o_pop = cur.seq == SQ_POP;
	// Pop walks the stack in reverse: CC first, PC last
	assign o_stk_sel = (cur.seq == SQ_POP) ? STK_LAST - cur.step : cur.step;
	assign o_pc_load = cur.seq == SQ_LOAD || cur.seq == SQ_RSTV;
	assign o_vector = cur.vector;
	assign o_wait = cur.mode == MD_WAIT;
	assign o_halt = cur.mode == MD_HALT;

	// ********************************
	// Checks
	// ********************************
	reset_mask_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> o_imask && o_pc_load && o_vector == VEC_RESET)
		else $error("reset did not leave mask set with reset vector");

	halt_freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.mode == MD_HALT && nxt.mode == MD_HALT |=> $stable(status_val))
		else $error("status register changed while halted");

	sw_toggle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.sw_irq_en && cur.mode != MD_HALT && sw_change |=> cur.sw_pend && cur.sw_flag == $past(sw_s))
		else $error("warning change raised no request");

	sw_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!cur.sw_irq_en && !cur.sw_pend |=> !cur.sw_pend)
		else $error("warning request raised while disabled");

	sw_autoclr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.seq == SQ_LOAD && cur.idx == SRC_SW && !sw_change |=> !cur.sw_pend)
		else $error("warning request not cleared on entry");

	push_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.seq == SQ_IDLE && nxt.seq == SQ_PUSH |=> o_push && o_stk_sel == 2'h0 ##1 o_stk_sel == 2'h1
		##1 o_stk_sel == 2'h2 ##1 o_stk_sel == 2'h3 ##1 o_pc_load && !o_push ##1 o_imask)
		else $error("service sequence out of order");

	ret_unmask_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.seq == SQ_IDLE && nxt.seq == SQ_POP |=> o_pop [*4] ##1 !o_imask && !o_busy)
		else $error("return did not pop four registers then unmask");

	trap_vec_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		trap_take |-> ##5 o_pc_load && o_vector == VEC_TRAP)
		else $error("trap did not reach its vector");

	mask_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.imask && cur.seq == SQ_IDLE && !trap_take |=> !o_push)
		else $error("masked request was serviced");

	halt_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cur.mode == MD_HALT && (req_vec & HALT_WAKE) == '0 |=> o_halt)
		else $error("left halt without a wake source");

	uv_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_wr && i_addr == SI_STATUS_OFF && !i_wdata[BIT_UV_RST] && !o_halt |=> !cur.uv_flag)
		else $error("under-voltage flag not cleared by write");
endmodule

/* hdl/ivs_sync.sv */
// Three-stage input synchroniser with an agreement filter.
// Assumes inputs are asynchronous levels; outputs are in the system clock domain.
`timescale 1ns/10ps
module ivs_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic [W-1:0] i_d, // Asynchronous levels
	output logic [W-1:0] o_q // Filtered levels
);
	typedef struct packed {
		logic [W-1:0] f1;
		logic [W-1:0] f2;
		logic [W-1:0] f3;
		logic [W-1:0] q;
	} ivs_sync_st_t;

	ivs_sync_st_t st_reg;
	ivs_sync_st_t st_next;

	// filtered capture
	// First stage feeds only the second; a change counts once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.f1 = i_d;
		st_next.f2 = st_reg.f1;
		st_next.f3 = st_reg.f2;
		for (int b = 0; b < W; b++) begin
			if (st_reg.f2[b] == st_reg.f3[b]) begin
				st_next.q[b] = st_reg.f3[b];
			end
		end
		if (!i_rst_n) begin
			st_next = '0;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st_reg <= st_next;
	end

	assign o_q = st_reg.q;
endmodule

/* inc/ivs_line_if.sv */
// Carrier between the controller and one external interrupt line.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface ivs_line_if;
	logic lvl;
	logic [1:0] sens;
	logic ack;
	logic req;
	modport line (input lvl, input sens, input ack, output req);
	modport ctl (output lvl, output sens, output ack, input req);
endinterface

/* inc/ivs_pkg.sv */
// Constants shared by the interrupt and supply-integrity block.
// Assumes a byte-wide register port and a 16-bit program counter.
package ivs_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] SI_STATUS_OFF = 8'h3A;
	localparam int BIT_SW_IRQ_EN = 0;
	localparam int BIT_SW_FLAG = 1;
	localparam int BIT_UV_RST = 2;
	localparam int BIT_PLL_LOCK = 3;
	localparam logic [3:0] RSVD_READ = 4'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ********************************
	// Vectors and sources
	// ********************************
	localparam int NSRC = 13;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_BASE = 16'hFFFA;
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam int SRC_EXT0 = 1;
	localparam int NEXT = 4;
	localparam logic [3:0] SRC_SW = 4'h7;
	localparam int SRC_PER0 = 8;
	localparam int NPER = 5;
	localparam logic [NSRC-1:0] HALT_WAKE = 13'h1A9E;

	// ********************************
	// External line inputs
	// ********************************
	localparam int PINS_PER_LINE = 2;
	localparam int NPIN = NEXT * PINS_PER_LINE;
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE = 2'h1;
	localparam logic [1:0] SENS_FALL = 2'h2;
	localparam logic [1:0] SENS_BOTH = 2'h3;

	// ********************************
	// Sequencing
	// ********************************
	localparam logic [1:0] STK_LAST = 2'h3;
	localparam logic RST_IMASK = 1'b1;
	localparam logic RST_LINE_PREV = 1'b1;

	typedef enum logic [1:0] {MD_RUN, MD_WAIT, MD_HALT} ivs_mode_t;
	typedef enum logic [2:0] {SQ_RSTV, SQ_IDLE, SQ_PUSH, SQ_LOAD, SQ_POP} ivs_seq_t;

endpackage
